// *** verilog/rea_pkg.sv ***
// Constants shared by the reactive energy accumulator.
package rea_pkg;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ------------------------------------------------------------
	localparam int AXI_AW = 20;
	localparam logic [15:0] IDX_TOT_A = 16'he406;
	localparam logic [15:0] IDX_TOT_B = 16'he407;
	localparam logic [15:0] IDX_TOT_C = 16'he408;
	localparam logic [15:0] IDX_FUND_A = 16'he409;
	localparam logic [15:0] IDX_FUND_B = 16'he40a;
	localparam logic [15:0] IDX_FUND_C = 16'he40b;
	localparam logic [15:0] IDX_STATUS = 16'he502;
	localparam logic [15:0] IDX_ENABLE = 16'he50a;
	localparam logic [15:0] IDX_PHASE_SIGN_REGISTER = 16'he617;
	localparam logic [15:0] IDX_COMPCFG = 16'he60e;
	localparam logic [15:0] IDX_MEASUREMENT_MODE_CONFIG = 16'he700;
	localparam logic [15:0] IDX_LCYC = 16'he702;
	localparam logic [15:0] IDX_ACCCFG = 16'he800;
	localparam logic [15:0] IDX_THR = 16'hea03;

	// ------------------------------------------------------------
	// Field positions.
	// ------------------------------------------------------------
	localparam int HF_TOT_BIT = 2;
	localparam int HF_FUND_BIT = 3;
	localparam int SIGNCHG_LSB = 10;
	localparam int PHASE_SIGN_REGISTER_LSB = 4;
	localparam int CLR_READ_BIT = 6;
	localparam int SIGN_SEL_BIT = 1;
	localparam int WIRING_LSB = 4;
	localparam int VAR_ACCUMULATE_SELECT_LSB = 2;
	localparam int HALF_BIT = 30;
	localparam int THR_ZERO_BITS = 27;
	localparam int THR_W = 35;

	// ------------------------------------------------------------
	// Reset values and encodings.
	// ------------------------------------------------------------
	localparam logic [7:0] THR_RST = 8'h03;
	localparam logic [15:0] COMPCFG_RST = 16'h0000;
	localparam logic [1:0] WIRE_THREE = 2'h1;
	localparam logic [1:0] WIRE_NEGA = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Timing: accumulation rate derived from the system clock.
	// ------------------------------------------------------------
	localparam int CLK_KHZ = 10000;
	localparam int ACC_KHZ = 1024;
	localparam logic [13:0] TICK_STEP = 14'(ACC_KHZ);
	localparam logic [13:0] TICK_WRAP = 14'(CLK_KHZ);

endpackage

// *** verilog/rea_reactive_energy.sv ***
// Reactive energy accumulator with AXI4-Lite register access.
// Overview of operation
// R1: Per phase, total and fundamental samples accumulate at 1.024 MHz.
// R2: At the threshold emit one pulse and subtract it, keeping residue.
// R3: Energy sign at the pulse becomes that phase's reactive power sign.
// R4: Pulses count in 32-bit counters, copied out when the register is read.
// R5: Threshold is the byte followed by 27 zeros, shared by all paths.
// R6: Threshold byte resets to three.
// R7: Software never writes a zero threshold, and should avoid below three.
// R8: Total energy in three consecutive registers, fundamental in next three.
// R9: Energy registers wrap around without saturating, either direction.
// R10: Status bit 2 sets when bit 30 of any total register changes.
// R11: Status bit 3 sets when bit 30 of any fundamental register changes.
// R12: Enabled half-full events drive the active-low interrupt line low.
// R13: Writing one clears a half-full status bit and releases the line.
// R14: With clear-on-read set, energy registers clear after being read.
// R15: Wiring select chooses voltages: 01 uses VA-VC, 11 uses -VA for B.
// R16: Two-bit accumulate field in accumulation config selects accumulation; the code stores bits 3:2 but always accumulates signed.
// R17: In three-wire mode phase B current is zero, accumulating nothing.
// R18: Software should drop phase B from frequency outputs in three-wire mode.
// R19: Sign change sets per-phase status bits 12:10 and sign bits.
// R20: Measurement mode bit 1 picks total or fundamental power for sign.
// R21: Negative power pulses at minus threshold, adds it back, counts down.
// R22: First-stage accumulator holds threshold plus a sample without overflow.
`timescale 1ns/10ps
`default_nettype none

module rea_reactive_energy
	import rea_pkg::*;
#(
	parameter int VW = 16,
	parameter int CW = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sampleValid,
	input wire logic [VW-1:0] voltA,
	input wire logic [VW-1:0] voltB,
	input wire logic [VW-1:0] voltC,
	input wire logic [CW-1:0] totCurA,
	input wire logic [CW-1:0] totCurB,
	input wire logic [CW-1:0] totCurC,
	input wire logic [CW-1:0] fundCurA,
	input wire logic [CW-1:0] fundCurB,
	input wire logic [CW-1:0] fundCurC,
	input wire logic [AXI_AW-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [AXI_AW-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic interruptRequestLine_n
);

	localparam int PW = VW + 1 + CW;
	// Two guard bits let a full threshold plus one sample sit unwrapped.
	localparam int ACC_W = ((PW > THR_W) ? PW : THR_W) + 2;

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	typedef struct packed {
		logic [13:0] phase;
		logic [5:0][PW-1:0] pwr;
		logic [5:0][ACC_W-1:0] acc;
		logic [5:0][31:0] cnt;
		logic [2:0] sign;
		logic [31:0] status;
		logic [31:0] enable;
		logic [15:0] compCfg;
		logic [7:0] measurement_mode_config;
		logic [7:0] lcyc;
		logic [7:0] accCfg;
		logic [7:0] thr;
		logic awHeld;
		logic [AXI_AW-1:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic irqN;
	} rea_state_t;

	rea_state_t s;
	rea_state_t next_s;

	// ------------------------------------------------------------
	// Power products per path; paths 0-2 total, 3-5 fundamental.
	// ------------------------------------------------------------
	logic [5:0][PW-1:0] prod;
	logic [VW:0] vSel [3];
	logic [CW-1:0] cur [6];
	logic [1:0] wiring;

	assign wiring = s.accCfg[WIRING_LSB+:2];
	assign cur[0] = totCurA;
	assign cur[1] = (wiring == WIRE_THREE) ? '0 : totCurB; // [R17]
	assign cur[2] = totCurC;
	assign cur[3] = fundCurA;
	assign cur[4] = (wiring == WIRE_THREE) ? '0 : fundCurB; // [R17]
	assign cur[5] = fundCurC;

	// Phase B voltage is rebuilt from A and C when no B wire exists.
	always_comb begin
		vSel[0] = {voltA[VW-1], voltA};
		vSel[2] = {voltC[VW-1], voltC};
		if (wiring == WIRE_THREE) begin
			vSel[1] = {voltA[VW-1], voltA} - {voltC[VW-1], voltC}; // [R15]
		end else if (wiring == WIRE_NEGA) begin
			vSel[1] = -{voltA[VW-1], voltA}; // [R15]
		end else begin
			vSel[1] = {voltB[VW-1], voltB}; // [R15]
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_path
			assign prod[gi] = PW'($signed(vSel[gi % 3]) * $signed(cur[gi]));
		end
	endgenerate

	// ------------------------------------------------------------
	// Byte-lane merge for register writes.
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b+:8] = data[8*b+:8];
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// Next-state logic.
	// ------------------------------------------------------------
	always_comb begin
		logic tick;
		logic [13:0] ph;
		logic [ACC_W-1:0] thrFull;
		logic [ACC_W-1:0] sum;
		logic [5:0] up;
		logic [5:0] dn;
		logic [5:0] clrCnt;
		logic [31:0] base;
		logic [31:0] setBits;
		logic [31:0] clrBits;
		logic [31:0] wv;
		logic [15:0] wIdx;
		logic [15:0] rIdx;
		logic [2:0] k;
		next_s = s;
		tick = 1'b0;
		up = '0;
		dn = '0;
		clrCnt = '0;
		setBits = '0;
		clrBits = '0;
		wv = '0;
		sum = '0;
		base = '0;
		k = '0;
		ph = '0;
		thrFull = '0;
		// Only word indices decode; the two low address bits are ignored.
		wIdx = 16'(s.awAddr[AXI_AW-1:2]);
		rIdx = 16'(araddr[AXI_AW-1:2]);

		// Fractional divider keeps the average rate exact at 1.024 MHz.
		// Ticks are unevenly spaced, so pulse timing jitters by one cycle.
		ph = s.phase + TICK_STEP;
		if (ph >= TICK_WRAP) begin
			ph = ph - TICK_WRAP;
			tick = 1'b1; // [R1]
		end
		next_s.phase = ph;
		if (sampleValid) begin
			next_s.pwr = prod;
		end

		thrFull = ACC_W'({s.thr, {THR_ZERO_BITS{1'b0}}}); // [R5]
		for (int i = 0; i < 6; i++) begin
			sum = s.acc[i];
			if (tick) begin
				sum = s.acc[i] + {{(ACC_W-PW){s.pwr[i][PW-1]}}, s.pwr[i]}; // [R1] [R22]
				if ($signed(sum) >= $signed(thrFull)) begin
					sum = sum - thrFull; // [R2]
					up[i] = 1'b1;
				end else if ($signed(sum) <= -$signed(thrFull)) begin
					sum = sum + thrFull; // [R21]
					dn[i] = 1'b1;
				end
			end
			next_s.acc[i] = sum;
		end

		// Sign of the selected power follows its first-stage pulses.
		// The stored sign starts positive, so a first negative pulse flags.
		for (int p = 0; p < 3; p++) begin
			k = s.measurement_mode_config[SIGN_SEL_BIT] ? 3'(p + 3) : 3'(p); // [R20]
			if (up[k] || dn[k]) begin
				next_s.sign[p] = dn[k]; // [R3]
				if (dn[k] != s.sign[p]) begin
					setBits[SIGNCHG_LSB+p] = 1'b1; // [R19]
				end
			end
		end

		// Register write, performed once address and data are both held.
		if (s.awHeld && s.wHeld) begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			if (wIdx == IDX_STATUS) begin
				clrBits = merge('0, s.wData, s.wStrb); // [R13]
			end else if (wIdx == IDX_ENABLE) begin
				next_s.enable = merge(s.enable, s.wData, s.wStrb);
			end else if (wIdx == IDX_COMPCFG) begin
				wv = merge({16'h0, s.compCfg}, s.wData, s.wStrb);
				next_s.compCfg = wv[15:0];
			end else if (wIdx == IDX_MEASUREMENT_MODE_CONFIG) begin
				wv = merge({24'h0, s.measurement_mode_config}, s.wData, s.wStrb);
				next_s.measurement_mode_config = wv[7:0];
			end else if (wIdx == IDX_LCYC) begin
				wv = merge({24'h0, s.lcyc}, s.wData, s.wStrb);
				next_s.lcyc = wv[7:0];
			end else if (wIdx == IDX_ACCCFG) begin
				wv = merge({24'h0, s.accCfg}, s.wData, s.wStrb);
				next_s.accCfg = wv[7:0]; // [R16]
			end else if (wIdx == IDX_THR) begin
				wv = merge({24'h0, s.thr}, s.wData, s.wStrb);
				next_s.thr = wv[7:0]; // [R7]
			end else if (wIdx >= IDX_TOT_A && wIdx <= IDX_FUND_C) begin
				next_s.bresp = RESP_OKAY;
			end else if (wIdx == IDX_PHASE_SIGN_REGISTER) begin
				next_s.bresp = RESP_OKAY;
			end else begin
				next_s.bresp = RESP_SLVERR;
			end
		end
		if (awvalid && s.awready) begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = awaddr;
		end
		if (wvalid && s.wready) begin
			next_s.wHeld = 1'b1;
			next_s.wData = wdata;
			next_s.wStrb = wstrb;
		end
		if (s.bvalid && bready) begin
			next_s.bvalid = 1'b0;
		end

		// Register read; energy counters are copied at the access.
		if (s.rvalid && rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		if (arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = '0;
			if (rIdx >= IDX_TOT_A && rIdx <= IDX_FUND_C) begin
				k = 3'(rIdx - IDX_TOT_A); // [R8]
				next_s.rdata = s.cnt[k]; // [R4]
				clrCnt[k] = s.lcyc[CLR_READ_BIT]; // [R14]
			end else if (rIdx == IDX_STATUS) begin
				next_s.rdata = s.status;
			end else if (rIdx == IDX_ENABLE) begin
				next_s.rdata = s.enable;
			end else if (rIdx == IDX_PHASE_SIGN_REGISTER) begin
				next_s.rdata = 32'({s.sign, {PHASE_SIGN_REGISTER_LSB{1'b0}}}); // [R19]
			end else if (rIdx == IDX_COMPCFG) begin
				next_s.rdata = {16'h0, s.compCfg};
			end else if (rIdx == IDX_MEASUREMENT_MODE_CONFIG) begin
				next_s.rdata = {24'h0, s.measurement_mode_config};
			end else if (rIdx == IDX_LCYC) begin
				next_s.rdata = {24'h0, s.lcyc};
			end else if (rIdx == IDX_ACCCFG) begin
				next_s.rdata = {24'h0, s.accCfg};
			end else if (rIdx == IDX_THR) begin
				next_s.rdata = {24'h0, s.thr};
			end else begin
				next_s.rresp = RESP_SLVERR;
			end
		end

		// Second stage; a pulse in the clearing cycle is kept.
		for (int i = 0; i < 6; i++) begin
			base = clrCnt[i] ? 32'h0 : s.cnt[i]; // [R14]
			if (up[i]) begin
				next_s.cnt[i] = base + 32'h1; // [R4] [R9]
			end else if (dn[i]) begin
				next_s.cnt[i] = base - 32'h1; // [R21] [R9]
			end else begin
				next_s.cnt[i] = base;
			end
			// Only a pulse counts as crossing, not a clear-on-read.
			if ((up[i] || dn[i]) &&
				(next_s.cnt[i][HALF_BIT] != base[HALF_BIT])) begin
				if (i < 3) begin
					setBits[HF_TOT_BIT] = 1'b1; // [R10]
				end else begin
					setBits[HF_FUND_BIT] = 1'b1; // [R11]
				end
			end
		end

		// A set arriving with its clear wins, so no event is lost.
		next_s.status = (s.status & ~clrBits) | setBits; // [R13]
		// The line follows the next status, so both move in one cycle.
		next_s.irqN = ~(|(next_s.status & next_s.enable)); // [R12]
		// One write at a time: both channels stall until the answer is taken.
		next_s.awready = ~next_s.awHeld & ~next_s.bvalid;
		next_s.wready = ~next_s.wHeld & ~next_s.bvalid;
	end

	// ------------------------------------------------------------
	// State register.
	// ------------------------------------------------------------
	// Reset is synchronous; the readies come up high while it is held.
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			s <= '0;
			s.thr <= THR_RST; // [R6]
			s.compCfg <= COMPCFG_RST;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.irqN <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all taken straight from the state register.
	// ------------------------------------------------------------

	assign awready = s.awready;
	assign wready = s.wready;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign arready = s.arready;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign interruptRequestLine_n = s.irqN;

endmodule

`default_nettype wire

// *** test/rea_dsp_model.sv ***
// Sample source standing in for the power computation engine.
`timescale 1ns/10ps
`default_nettype none
module rea_dsp_model (
	input wire logic clock,
	input wire logic load,
	input wire logic [15:0] val [9],
	output logic sampleValid,
	output logic [15:0] bus [9]
);
	logic [15:0] junk = 16'h5a5a;
	// Lines change every cycle outside a load, so a stray latch is seen.
	always @(posedge clock) begin
		junk <= ~junk + 16'h0001;
		sampleValid <= load;
		for (int i = 0; i < 9; i++) begin
			bus[i] <= load ? val[i] : junk ^ 16'(i);
		end
	end
endmodule
`default_nettype wire

// *** test/rea_checker.sv ***
// Port checks for the reactive energy accumulator.
`timescale 1ns/10ps
`default_nettype none
module rea_checker
	import rea_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic interruptRequestLine_n
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_R_LATENCY: assert property (arvalid && arready |=> rvalid)
		else $error("read answer not one cycle after address");
	AST_R_STANDS: assert property (rvalid && !rready
		|=> rvalid && $stable(rdata))
		else $error("read data dropped before ready");
	AST_R_DROP: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read answer not released");
	AST_R_BUSY: assert property (rvalid |-> !arready)
		else $error("read address accepted while answering");
	AST_SLVERR_ZERO: assert property (rvalid && rresp == RESP_SLVERR
		|-> rdata == 32'h0)
		else $error("refused read carries data");
	AST_B_LATENCY: assert property (awvalid && awready
		&& wvalid && wready |-> ##2 bvalid)
		else $error("write response not two cycles after transfer");
	AST_B_STANDS: assert property (bvalid && !bready
		|=> bvalid && $stable(bresp))
		else $error("write response dropped before ready");
	AST_B_BUSY: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while responding");
	AST_IRQ_RELEASE: assert property ($rose(interruptRequestLine_n)
		|-> bvalid || $past(bvalid) || $past(bvalid, 2))
		else $error("interrupt released without a register write");
endmodule
bind rea_reactive_energy rea_checker i_chk (.clock, .rst_n, .awvalid,
	.awready, .wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready,
	.rdata, .rresp, .rvalid, .rready, .interruptRequestLine_n);
`default_nettype wire

// *** test/tb_reactive_energy_accumulator.sv ***
// Self-checking bench for the reactive energy accumulator.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	mismatches++; $display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_reactive_energy_accumulator import rea_pkg::*;;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic load = 1'b0;
	logic [15:0] val [9];
	logic [15:0] bus [9];
	logic sampleValid, awready, wready, bvalid, arready, rvalid;
	logic interruptRequestLine_n;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [31:0] wdata = '0, rdata, d;
	logic [1:0] bresp, rresp, r;
	logic [31:0] got [6];
	logic [1:0] wires [3] = '{2'h0, WIRE_NEGA, WIRE_THREE};
	logic [31:0] st [3] = '{32'h100c, 32'h180c, 32'h40c};
	logic [31:0] ps [3] = '{32'h40, 32'h60, 32'h10};
	int mismatches = 0, samples_checked = 0, n, e, t, nc;
	always #50 clock = ~clock;
	rea_dsp_model i_dsp (.clock(clock), .load(load), .val(val),
		.sampleValid(sampleValid), .bus(bus));
	rea_reactive_energy i_dut (.clock(clock), .rst_n(rst_n),
		.sampleValid(sampleValid), .voltA(bus[0]), .voltB(bus[1]),
		.voltC(bus[2]), .totCurA(bus[3]), .totCurB(bus[4]), .totCurC(bus[5]),
		.fundCurA(bus[6]), .fundCurB(bus[7]), .fundCurC(bus[8]),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .interruptRequestLine_n(interruptRequestLine_n));
	// ------------------------------------------------------------
	// Bus cycles and expectations.
	// ------------------------------------------------------------
	task automatic wr(input logic [15:0] idx, input logic [31:0] v);
		awaddr <= AXI_AW'({idx, 2'b00});
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (awvalid || wvalid || !bvalid);
		r = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [15:0] idx, output logic [31:0] v);
		araddr <= AXI_AW'({idx, 2'b00});
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		v = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic pulse;
		load <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
	endtask
	// Products sit at zero or plus or minus one or one half threshold so counts are exact.
	task automatic run;
		val = '{16'(t * 8192), 16'(t * 8192), 16'(t * 8192), 16'h4000,
			16'h2000, 16'hc000, 16'he000, 16'h2000, 16'h4000};
		pulse;
		repeat (nc) @(posedge clock);
		val = '{default: 16'h0};
		pulse;
		repeat (40) @(posedge clock);
		for (int i = 0; i < 6; i++) rd(IDX_TOT_A + 16'(i), got[i]);
	endtask
	function automatic logic [31:0] cnt_of(int i, int k, int m);
		int sb;
		sb = k == 0 ? 1 : (k == 1 ? -1 : 0);
		case (i)
			1, 4: return 32'(sb * (m / 2));
			2: return 32'(-m);
			3: return 32'(-(m / 2));
			default: return 32'(m);
		endcase
	endfunction
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		mismatches++;
		end_sim;
	end
	initial begin
		val = '{default: 16'h0};
		void'($urandom(34));
		for (int k = 0; k < 3; k++) begin
			rst_n <= 1'b0;
			repeat (4) @(posedge clock);
			rst_n <= 1'b1;
			@(posedge clock);
			if (k == 0) begin
				rd(IDX_THR, d);
				`CHK(d, 32'(THR_RST))
				rd(16'h0001, d);
				`CHK({r, d}, {RESP_SLVERR, 32'h0})
				wr(IDX_TOT_A, 32'h5);
				rd(IDX_TOT_A, d);
				`CHK(d, 32'h0)
				wr(16'h0001, 32'h0);
				`CHK(r, RESP_SLVERR)
			end
			t = $urandom_range(3, 1);
			nc = $urandom_range(600, 200);
			wr(IDX_THR, 32'(t));
			wr(IDX_ACCCFG, {26'h0, wires[k], 2'(k), 2'h0});
			wr(IDX_MEASUREMENT_MODE_CONFIG, k == 2 ? 32'h2 : 32'h0);
			wr(IDX_COMPCFG, 32'h0);
			rd(IDX_ACCCFG, d);
			`CHK(d, {26'h0, wires[k], 2'(k), 2'h0})
			run;
			n = int'(got[0]);
			e = nc * 1024 / 10000;
			`CHK(n > e - 3 && n < e + 3, 1'b1)
			for (int i = 1; i < 6; i++) begin
				`CHK(got[i], cnt_of(i, k, n))
			end
			rd(IDX_PHASE_SIGN_REGISTER, d);
			`CHK(d, ps[k])
			wr(IDX_STATUS, 32'h0);
			rd(IDX_STATUS, d);
			`CHK(d, st[k])
			wr(IDX_ENABLE, st[k]);
			repeat (3) @(negedge clock);
			`CHK(interruptRequestLine_n, 1'b0)
			@(posedge clock);
			wr(IDX_STATUS, st[k]);
			repeat (3) @(negedge clock);
			`CHK(interruptRequestLine_n, 1'b1)
			@(posedge clock);
			wr(IDX_LCYC, 32'h40);
			rd(IDX_TOT_C, d);
			`CHK(d, 32'(-n))
			rd(IDX_TOT_C, d);
			`CHK(d, 32'h0)
			$display("test %0d done", k);
		end
		end_sim;
	end
endmodule
`default_nettype wire
